// [design/ltj_cfg.svh]
`ifndef LTJ_CFG_SVH
`define LTJ_CFG_SVH
// Purpose: offsets, field positions and reset values of the line configuration bank
// Assumes: byte-wide host register port
// Notes: definitions only
`define LTJ_OFF_SWRST 8'h01
`define LTJ_OFF_GLOBAL 8'h02
`define LTJ_OFF_TERM 8'h03
`define LTJ_OFF_JITTER 8'h04
`define LTJ_OFF_TXCFG 8'h05
// Global register
`define LTJ_GLB_STD_BIT 2
`define LTJ_GLB_MASK 8'h07
`define LTJ_GLB_RST 8'h00
// Termination register
`define LTJ_TERM_TX_LSB 3
`define LTJ_TERM_RX_LSB 0
`define LTJ_TERM_EXT_BIT 2
`define LTJ_TERM_MASK 8'h3f
`define LTJ_TERM_RST 8'h00
// Jitter register
`define LTJ_JIT_LIMIT_BIT 5
`define LTJ_JIT_PLACE_LSB 3
`define LTJ_JIT_DEPTH_LSB 1
`define LTJ_JIT_CORNER_BIT 0
`define LTJ_JIT_MASK 8'h3f
`define LTJ_JIT_RST 8'h20
// Transmit register
`define LTJ_TX_PD_BIT 4
`define LTJ_TX_INV_BIT 3
`define LTJ_TX_EDGE_BIT 2
`define LTJ_TX_MODE_LSB 0
`define LTJ_TX_MASK 8'h1f
`define LTJ_TX_RST 8'h00
// Attenuator buffer depths in bits
`define LTJ_DEPTH_128 8'h80
`define LTJ_DEPTH_64 8'h40
`define LTJ_DEPTH_32 8'h20
// Jitter corners in units of 0.01 Hz
`define LTJ_CORNER_E1_WIDE 10'h2a8
`define LTJ_CORNER_T1_WIDE 10'h1f4
`define LTJ_CORNER_E1_NARROW 10'h05a
`define LTJ_CORNER_T1_NARROW 10'h07d
`endif

// [design/ltj_pkg.sv]
// Purpose: shared types of the line configuration bank
// Assumes: nothing
// Notes: constants live in ltj_cfg.svh
package ltj_pkg;
  typedef enum logic [1:0] {
    LTJ_MODE_SUBST = 2'h0,
    LTJ_MODE_AMI = 2'h1,
    LTJ_MODE_RAIL = 2'h2,
    LTJ_MODE_RAIL_ALT = 2'h3
  } ltj_mode_t;
  // Pulse slot codes in the encoder delay line
  typedef enum logic [1:0] {
    LTJ_SLOT_SPACE = 2'h0,
    LTJ_SLOT_MARK = 2'h1,
    LTJ_SLOT_VIOL = 2'h2,
    LTJ_SLOT_FILL = 2'h3
  } ltj_slot_t;
endpackage

// [design/ltj_tx_if.sv]
// Purpose: carries sampled transmit data between register bank and encoder
// Assumes: single clock domain
// Notes: ctl drives, enc answers
`timescale 1ns/10ps
interface ltj_tx_if;
  import ltj_pkg::*;
  logic strobe;
  ltj_mode_t mode;
  logic t1;
  logic data;
  logic pos_in;
  logic neg_in;
  logic pos_out;
  logic neg_out;
  modport ctl (output strobe, mode, t1, data, pos_in, neg_in, input pos_out, neg_out);
  modport enc (input strobe, mode, t1, data, pos_in, neg_in, output pos_out, neg_out);
endinterface

// [design/ltj_tx_encoder.sv]
// Purpose: line encoder for the transmit path (substitution, AMI, dual-rail bypass)
// Assumes: strobe marks one sampled bit per pulse
// Notes: substitution codes need a delay line of 4 (E1) or 8 (T1) bits
`timescale 1ns/10ps
module ltj_tx_encoder
  import ltj_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  ltj_tx_if.enc tx
);
  ltj_slot_t slot_reg [DEPTH];
  logic last_pos_reg;
  logic odd_marks_reg;
  logic pos_reg;
  logic neg_reg;
  ltj_slot_t new_slot;
  ltj_slot_t out_slot;
  logic quiet3;
  logic quiet7;
  logic sub_odd;

  assign tx.pos_out = pos_reg;
  assign tx.neg_out = neg_reg;

  always_comb begin
    quiet3 = 1'b1;
    quiet7 = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (slot_reg[i] != LTJ_SLOT_SPACE) begin
        quiet7 = 1'b0;
        if (i < 3) begin
          quiet3 = 1'b0;
        end
      end
    end
    new_slot = tx.data ? LTJ_SLOT_MARK : LTJ_SLOT_SPACE;
    // Parity must include the slot leaving this cycle; a leaving violation restarts it
    sub_odd = (slot_reg[3] == LTJ_SLOT_VIOL) ? 1'b0 : odd_marks_reg ^ (slot_reg[3] == LTJ_SLOT_MARK);
    if (tx.mode == LTJ_MODE_AMI) begin
      out_slot = new_slot;
    end else if (tx.t1) begin
      out_slot = slot_reg[DEPTH-1];
    end else begin
      out_slot = slot_reg[3];
    end
  end

  // ==========================================================================
  // Delay line with zero substitution
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        slot_reg[i] <= LTJ_SLOT_SPACE;
      end
    end else if (tx.strobe) begin
      for (int i = 1; i < DEPTH; i++) begin
        slot_reg[i] <= slot_reg[i-1];
      end
      slot_reg[0] <= new_slot;
      if (tx.mode == LTJ_MODE_SUBST && !tx.data) begin
        if (tx.t1 && quiet7) begin
          // Oldest first: 0 0 0 V B 0 V B
          slot_reg[0] <= LTJ_SLOT_MARK;
          slot_reg[1] <= LTJ_SLOT_VIOL;
          slot_reg[2] <= LTJ_SLOT_FILL;
          slot_reg[3] <= LTJ_SLOT_MARK;
          slot_reg[4] <= LTJ_SLOT_VIOL;
          slot_reg[5] <= LTJ_SLOT_FILL;
          slot_reg[6] <= LTJ_SLOT_FILL;
          slot_reg[7] <= LTJ_SLOT_FILL;
        end else if (!tx.t1 && quiet3) begin
          // Odd marks since the last violation need no balancing pulse
          slot_reg[0] <= LTJ_SLOT_VIOL;
          slot_reg[1] <= LTJ_SLOT_FILL;
          slot_reg[2] <= LTJ_SLOT_FILL;
          slot_reg[3] <= sub_odd ? LTJ_SLOT_FILL : LTJ_SLOT_MARK;
        end
      end
    end
  end

  // ==========================================================================
  // Pulse polarity and rail outputs
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last_pos_reg <= 1'b0;
      odd_marks_reg <= 1'b0;
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else if (tx.strobe) begin
      if (tx.mode == LTJ_MODE_RAIL || tx.mode == LTJ_MODE_RAIL_ALT) begin
        pos_reg <= tx.pos_in;
        neg_reg <= tx.neg_in;
      end else begin
        case (out_slot)
          LTJ_SLOT_MARK: begin
            pos_reg <= ~last_pos_reg;
            neg_reg <= last_pos_reg;
            last_pos_reg <= ~last_pos_reg;
            odd_marks_reg <= ~odd_marks_reg;
          end
          LTJ_SLOT_VIOL: begin
            pos_reg <= last_pos_reg;
            neg_reg <= ~last_pos_reg;
            odd_marks_reg <= 1'b0;
          end
          default: begin
            pos_reg <= 1'b0;
            neg_reg <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// [design/ltj_top.sv]
// Purpose: line termination, jitter attenuator and transmit configuration bank
// Assumes: host port and transmit pins synchronous to I_SYS_CLK
// Notes: tx_line_clock is oversampled; it must run well below I_SYS_CLK / 2
`timescale 1ns/10ps
`include "ltj_cfg.svh"
module ltj_top
  import ltj_pkg::*;
(
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  // Host register port
  input wire logic [7:0] I_HOST_ADDR,
  input wire logic I_HOST_WR,
  input wire logic I_HOST_RD,
  input wire logic [7:0] I_HOST_WDATA,
  output logic [7:0] O_HOST_RDATA,
  output logic O_HOST_RVALID,
  // Framer transmit side
  input wire logic I_TX_LINE_CLOCK,
  input wire logic I_TX_SINGLE_RAIL_IN,
  input wire logic I_TX_POSITIVE_RAIL_IN,
  input wire logic I_TX_NEGATIVE_RAIL_IN,
  // Line driver
  output logic O_TX_LINE_POS,
  output logic O_TX_LINE_NEG,
  output logic O_TX_LINE_OE,
  output logic O_TX_POWER_DOWN,
  // Termination control
  output logic [1:0] O_TX_TERM_SEL,
  output logic O_TX_TERM_EXT,
  output logic [1:0] O_RX_TERM_SEL,
  output logic O_RX_TERM_EXT,
  // Jitter attenuator control
  output logic O_JITTER_LIMIT_MODE,
  output logic O_JITTER_IN_TX,
  output logic O_JITTER_IN_RX,
  output logic [7:0] O_JITTER_DEPTH_BITS,
  output logic [9:0] O_JITTER_CORNER_CHZ,
  // Global standard
  output logic O_GLOBAL_LINE_STANDARD
);
  logic [7:0] global_reg;
  logic [7:0] term_reg;
  logic [7:0] jitter_reg;
  logic [7:0] txcfg_reg;
  logic tx_line_clock_prev_reg;
  logic soft_rst;
  logic cfg_rst;
  logic t1_mode;
  logic [1:0] placement;
  logic [1:0] depth_code;
  ltj_mode_t tx_encoder_mode;
  logic tx_data_invert;
  logic tx_clock_edge_select;
  logic tx_rise;
  logic tx_fall;

  ltj_tx_if tx ();

  assign soft_rst = I_HOST_WR && (I_HOST_ADDR == `LTJ_OFF_SWRST);
  assign cfg_rst = I_SYS_RST || soft_rst;
  assign t1_mode = global_reg[`LTJ_GLB_STD_BIT];
  assign placement = jitter_reg[`LTJ_JIT_PLACE_LSB +: 2];
  assign depth_code = jitter_reg[`LTJ_JIT_DEPTH_LSB +: 2];
  assign tx_encoder_mode = ltj_mode_t'(txcfg_reg[`LTJ_TX_MODE_LSB +: 2]);
  assign tx_data_invert = txcfg_reg[`LTJ_TX_INV_BIT];
  assign tx_clock_edge_select = txcfg_reg[`LTJ_TX_EDGE_BIT];

  // ==========================================================================
  // Register file
  // ==========================================================================
  // The line standard survives a soft reset; only the hard reset clears it
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      global_reg <= `LTJ_GLB_RST;
    end else if (I_HOST_WR && I_HOST_ADDR == `LTJ_OFF_GLOBAL) begin
      global_reg <= I_HOST_WDATA & `LTJ_GLB_MASK;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (cfg_rst) begin
      term_reg <= `LTJ_TERM_RST;
      jitter_reg <= `LTJ_JIT_RST;
      txcfg_reg <= `LTJ_TX_RST;
    end else if (I_HOST_WR) begin
      case (I_HOST_ADDR)
        `LTJ_OFF_TERM: term_reg <= I_HOST_WDATA & `LTJ_TERM_MASK;
        `LTJ_OFF_JITTER: jitter_reg <= I_HOST_WDATA & `LTJ_JIT_MASK;
        `LTJ_OFF_TXCFG: txcfg_reg <= I_HOST_WDATA & `LTJ_TX_MASK;
        default: begin
        end
      endcase
    end
  end

  // Reads answer one cycle later; unmapped and write-only offsets read zero
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      O_HOST_RDATA <= 8'h00;
      O_HOST_RVALID <= 1'b0;
    end else begin
      O_HOST_RVALID <= I_HOST_RD;
      if (I_HOST_RD) begin
        case (I_HOST_ADDR)
          `LTJ_OFF_GLOBAL: O_HOST_RDATA <= global_reg;
          `LTJ_OFF_TERM: O_HOST_RDATA <= term_reg;
          `LTJ_OFF_JITTER: O_HOST_RDATA <= jitter_reg;
          `LTJ_OFF_TXCFG: O_HOST_RDATA <= txcfg_reg;
          default: O_HOST_RDATA <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================================
  // Decoded configuration outputs
  // ==========================================================================
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      O_TX_TERM_SEL <= 2'h0;
      O_TX_TERM_EXT <= 1'b0;
      O_RX_TERM_SEL <= 2'h0;
      O_RX_TERM_EXT <= 1'b0;
      O_GLOBAL_LINE_STANDARD <= 1'b0;
    end else begin
      O_TX_TERM_SEL <= term_reg[`LTJ_TERM_TX_LSB +: 2];
      // External transmit matching exists only on E1
      O_TX_TERM_EXT <= term_reg[`LTJ_TERM_TX_LSB + `LTJ_TERM_EXT_BIT] && !t1_mode;
      O_RX_TERM_SEL <= term_reg[`LTJ_TERM_RX_LSB +: 2];
      O_RX_TERM_EXT <= term_reg[`LTJ_TERM_RX_LSB + `LTJ_TERM_EXT_BIT];
      O_GLOBAL_LINE_STANDARD <= t1_mode;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      O_JITTER_LIMIT_MODE <= 1'b1;
      O_JITTER_IN_TX <= 1'b0;
      O_JITTER_IN_RX <= 1'b0;
      O_JITTER_DEPTH_BITS <= `LTJ_DEPTH_128;
      O_JITTER_CORNER_CHZ <= `LTJ_CORNER_E1_WIDE;
    end else begin
      O_JITTER_LIMIT_MODE <= jitter_reg[`LTJ_JIT_LIMIT_BIT];
      O_JITTER_IN_TX <= (placement == 2'h1);
      O_JITTER_IN_RX <= (placement == 2'h3);
      if (depth_code[1]) begin
        O_JITTER_DEPTH_BITS <= `LTJ_DEPTH_32;
      end else if (depth_code[0]) begin
        O_JITTER_DEPTH_BITS <= `LTJ_DEPTH_64;
      end else begin
        O_JITTER_DEPTH_BITS <= `LTJ_DEPTH_128;
      end
      case ({jitter_reg[`LTJ_JIT_CORNER_BIT], t1_mode})
        2'h0: O_JITTER_CORNER_CHZ <= `LTJ_CORNER_E1_WIDE;
        2'h1: O_JITTER_CORNER_CHZ <= `LTJ_CORNER_T1_WIDE;
        2'h2: O_JITTER_CORNER_CHZ <= `LTJ_CORNER_E1_NARROW;
        default: O_JITTER_CORNER_CHZ <= `LTJ_CORNER_T1_NARROW;
      endcase
    end
  end

  // ==========================================================================
  // Transmit sampling
  // ==========================================================================
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      tx_line_clock_prev_reg <= 1'b0;
    end else begin
      tx_line_clock_prev_reg <= I_TX_LINE_CLOCK;
    end
  end

  assign tx_rise = I_TX_LINE_CLOCK && !tx_line_clock_prev_reg;
  assign tx_fall = !I_TX_LINE_CLOCK && tx_line_clock_prev_reg;
  assign tx.strobe = tx_clock_edge_select ? tx_rise : tx_fall;
  assign tx.mode = tx_encoder_mode;
  assign tx.t1 = t1_mode;
  assign tx.data = I_TX_SINGLE_RAIL_IN ^ tx_data_invert;
  assign tx.pos_in = I_TX_POSITIVE_RAIL_IN ^ tx_data_invert;
  assign tx.neg_in = I_TX_NEGATIVE_RAIL_IN ^ tx_data_invert;

  ltj_tx_encoder #(
    .DEPTH(8)
  ) u_encoder (
    .i_clk(I_SYS_CLK),
    .i_rst(cfg_rst),
    .tx(tx)
  );

  // ==========================================================================
  // Line driver
  // ==========================================================================
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      O_TX_LINE_POS <= 1'b0;
      O_TX_LINE_NEG <= 1'b0;
      O_TX_LINE_OE <= 1'b0;
      O_TX_POWER_DOWN <= 1'b0;
    end else begin
      O_TX_POWER_DOWN <= txcfg_reg[`LTJ_TX_PD_BIT];
      O_TX_LINE_OE <= !txcfg_reg[`LTJ_TX_PD_BIT] && !soft_rst;
      O_TX_LINE_POS <= tx.pos_out && !txcfg_reg[`LTJ_TX_PD_BIT];
      O_TX_LINE_NEG <= tx.neg_out && !txcfg_reg[`LTJ_TX_PD_BIT];
    end
  end
endmodule

// [test/ltj_top_monitor.sv]
// Purpose: port checks of ltj_top
// Assumes: decoded outputs follow a register write two edges later
// Notes: attached by bind
`timescale 1ns/10ps
module ltj_top_monitor (
  input wire logic I_SYS_CLK, I_SYS_RST, I_HOST_WR, I_HOST_RD,
  input wire logic [7:0] I_HOST_ADDR, I_HOST_WDATA, O_HOST_RDATA,
  input wire logic O_HOST_RVALID, O_TX_LINE_POS, O_TX_LINE_NEG, O_TX_LINE_OE,
  input wire logic O_TX_POWER_DOWN, O_TX_TERM_EXT, O_RX_TERM_EXT,
  input wire logic [1:0] O_TX_TERM_SEL, O_RX_TERM_SEL,
  input wire logic O_JITTER_LIMIT_MODE, O_JITTER_IN_TX, O_JITTER_IN_RX,
  input wire logic [7:0] O_JITTER_DEPTH_BITS,
  input wire logic [9:0] O_JITTER_CORNER_CHZ,
  input wire logic O_GLOBAL_LINE_STANDARD
);
  // ==========
  // Helpers
  logic [7:0] wd_d1;
  logic [7:0] wd_d2;
  // Write data as it stood when the decode catches up
  always_ff @(posedge I_SYS_CLK) begin
    wd_d1 <= I_HOST_WDATA;
    wd_d2 <= wd_d1;
  end
  default clocking mon_cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence term_wr; I_HOST_WR && I_HOST_ADDR == 8'h03; endsequence
  sequence jit_wr; I_HOST_WR && I_HOST_ADDR == 8'h04; endsequence
  // ==========
  // Assertions
  tx_term_a: assert property (term_wr |-> ##2 O_TX_TERM_SEL == wd_d2[4:3] &&
    O_TX_TERM_EXT == (wd_d2[5] && !O_GLOBAL_LINE_STANDARD)) else $error("tx termination decode");
  rx_term_a: assert property (term_wr |-> ##2 {O_RX_TERM_EXT, O_RX_TERM_SEL} == wd_d2[2:0])
    else $error("rx termination decode");
  jit_limit_a: assert property (jit_wr |-> ##2 O_JITTER_LIMIT_MODE == wd_d2[5])
    else $error("limit mode decode");
  jit_place_a: assert property (jit_wr |-> ##2 O_JITTER_IN_TX == (wd_d2[4:3] == 2'h1) &&
    O_JITTER_IN_RX == (wd_d2[4:3] == 2'h3)) else $error("placement decode");
  jit_depth_a: assert property (jit_wr |-> ##2 O_JITTER_DEPTH_BITS ==
    (wd_d2[2] ? 8'h20 : wd_d2[1] ? 8'h40 : 8'h80)) else $error("depth decode");
  jit_corner_a: assert property (jit_wr |-> ##2 O_JITTER_CORNER_CHZ == (wd_d2[0] ?
    (O_GLOBAL_LINE_STANDARD ? 10'h07d : 10'h05a) : (O_GLOBAL_LINE_STANDARD ? 10'h1f4 : 10'h2a8)))
    else $error("corner decode");
  pd_quiet_a: assert property (O_TX_POWER_DOWN && $past(O_TX_POWER_DOWN) |->
    !O_TX_LINE_OE && !O_TX_LINE_POS && !O_TX_LINE_NEG) else $error("driver active in power-down");
  soft_rst_a: assert property (I_HOST_WR && I_HOST_ADDR == 8'h01 |=> !O_TX_LINE_OE ##1
    O_JITTER_LIMIT_MODE && O_JITTER_DEPTH_BITS == 8'h80 && !O_JITTER_IN_TX) else $error("soft reset");
  rd_zero_a: assert property (I_HOST_RD && (I_HOST_ADDR == 8'h01 || I_HOST_ADDR > 8'h05) |=>
    O_HOST_RVALID && O_HOST_RDATA == 8'h00) else $error("unmapped read not zero");
endmodule
bind ltj_top ltj_top_monitor mon_u (.*);

// [test/ltj_framer_model.sv]
// Purpose: framer model driving transmit clock and data
// Assumes: line clock period of eight system clocks
// Notes: clock stands low between frames
`timescale 1ns/10ps
module ltj_framer_model (
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic i_edge_sel,
  input wire logic i_invert,
  input wire logic [15:0] i_pat_s,
  input wire logic [15:0] i_pat_n,
  output logic o_line_clock,
  output logic o_single = 1'b0,
  output logic o_pos = 1'b0,
  output logic o_neg = 1'b1
);
  logic [2:0] cnt_reg = 3'h0;
  logic [3:0] idx_reg = 4'h0;
  assign o_line_clock = cnt_reg[2];
  always_ff @(posedge i_clk) begin
    cnt_reg <= i_run ? cnt_reg + 3'h1 : 3'h0;
    // Data moves on the edge not sampled, giving half a period of setup
    if (i_run && cnt_reg == (i_edge_sel ? 3'h7 : 3'h3)) begin
      idx_reg <= idx_reg + 4'h1;
      o_single <= i_pat_s[idx_reg] ^ i_invert;
      o_pos <= i_pat_s[idx_reg] ^ i_invert;
      o_neg <= i_pat_n[idx_reg] ^ i_invert;
    end else if (!i_run) begin
      // Released lines toggle so a stale level never passes for data
      {o_single, o_pos, o_neg} <= ~{o_single, o_pos, o_neg};
    end
  end
endmodule

// [test/ltj_top_test.sv]
// Purpose: self-checking bench of ltj_top
// Assumes: framer model supplies the transmit pins
// Notes: field decodes are judged by the bound checker
`timescale 1ns/10ps
module ltj_top_test;
  logic I_SYS_CLK = 1'b0, I_SYS_RST = 1'b1, I_HOST_WR = 1'b0, I_HOST_RD = 1'b0;
  logic [7:0] I_HOST_ADDR = 8'h00, I_HOST_WDATA = 8'h00, O_HOST_RDATA, O_JITTER_DEPTH_BITS;
  logic O_HOST_RVALID, O_TX_LINE_POS, O_TX_LINE_NEG, O_TX_LINE_OE, O_TX_POWER_DOWN, O_TX_TERM_EXT;
  logic O_RX_TERM_EXT, O_JITTER_LIMIT_MODE, O_JITTER_IN_TX, O_JITTER_IN_RX, O_GLOBAL_LINE_STANDARD;
  logic I_TX_LINE_CLOCK, I_TX_SINGLE_RAIL_IN, I_TX_POSITIVE_RAIL_IN, I_TX_NEGATIVE_RAIL_IN;
  logic [1:0] O_TX_TERM_SEL, O_RX_TERM_SEL;
  logic [9:0] O_JITTER_CORNER_CHZ;
  logic run = 1'b0, edge_sel = 1'b0, inv = 1'b0;
  logic [15:0] pat_s = 16'h0000, pat_n = 16'h0000;
  int bad_count = 0, checks = 0;
  // Rows: address, write data, read back
  logic [23:0] rows [8] = '{24'h03ff3f, 24'h04ff3f, 24'h05ff1f, 24'h02ff07,
    24'h1fff00, 24'h015500, 24'h04c000, 24'h020000};
  // Rows: config, single or positive pattern, negative pattern, pos marks, neg marks
  logic [55:0] tx_rows [6] = '{56'h01ffff00000808, 56'h0dffff00000808, 56'h01000000000000,
    56'h02ffff00001000, 56'h0b0000ffff0010, 56'h11ffff00000000};
  always #12.5 I_SYS_CLK = ~I_SYS_CLK;
  ltj_top dut_u (.*);
  ltj_framer_model frm_u (.i_clk(I_SYS_CLK), .i_run(run), .i_edge_sel(edge_sel), .i_invert(inv),
    .i_pat_s(pat_s), .i_pat_n(pat_n), .o_line_clock(I_TX_LINE_CLOCK), .o_single(I_TX_SINGLE_RAIL_IN),
    .o_pos(I_TX_POSITIVE_RAIL_IN), .o_neg(I_TX_NEGATIVE_RAIL_IN));
  // ==========
  // Tasks
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string name, logic [9:0] exp, logic [9:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge I_SYS_CLK);
    I_HOST_ADDR <= a;
    I_HOST_WDATA <= d;
    I_HOST_WR <= 1'b1;
    @(posedge I_SYS_CLK);
    I_HOST_WR <= 1'b0;
  endtask
  task automatic rdchk(string name, logic [7:0] a, logic [7:0] e);
    int n;
    @(posedge I_SYS_CLK);
    I_HOST_ADDR <= a;
    I_HOST_RD <= 1'b1;
    @(posedge I_SYS_CLK);
    I_HOST_RD <= 1'b0;
    #1;
    for (n = 0; n < 4 && O_HOST_RVALID !== 1'b1; n++) @(posedge I_SYS_CLK) #1;
    if (n == 4) begin bad_count++; end_sim(); end
    chk(name, 10'(e), 10'(O_HOST_RDATA));
  endtask
  // Counts line marks over 16 periods after 8 periods of settling
  task automatic marks(output int p, output int q, output int a);
    int i, w;
    logic last;
    p = 0;
    q = 0;
    a = 0;
    last = 1'bx;
    for (i = 0; i < 24; i++) begin
      for (w = 0; w < 20 && I_TX_LINE_CLOCK === edge_sel; w++) @(posedge I_SYS_CLK);
      if (w == 20) begin bad_count++; end_sim(); end
      for (w = 0; w < 20 && I_TX_LINE_CLOCK !== edge_sel; w++) @(posedge I_SYS_CLK);
      if (w == 20) begin bad_count++; end_sim(); end
      repeat (6) @(posedge I_SYS_CLK);
      #1;
      if (i >= 8 && (O_TX_LINE_POS | O_TX_LINE_NEG) === 1'b1) begin
        p += O_TX_LINE_POS;
        q += O_TX_LINE_NEG;
        if (O_TX_LINE_POS === last) a++;
        last = O_TX_LINE_POS;
      end
    end
  endtask
  // ==========
  // Sequence
  initial begin
    int i, p, q, a;
    logic [55:0] t;
    repeat (10) @(posedge I_SYS_CLK);
    I_SYS_RST <= 1'b0;
    for (i = 0; i < 8; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdchk("readback", rows[i][23:16], rows[i][7:0]);
    end
    // Every field code in both line standards, decodes judged by the checker
    for (i = 0; i < 16; i++) begin
      if (i == 8) wr(8'h02, 8'h04);
      wr(8'h03, 8'(i % 8 * 9));
      wr(8'h04, 8'(i % 8 * 9));
    end
    I_SYS_RST <= 1'b1;
    repeat (2) @(posedge I_SYS_CLK);
    I_SYS_RST <= 1'b0;
    rdchk("term reset", 8'h03, 8'h00);
    rdchk("jitter reset", 8'h04, 8'h20);
    rdchk("tx reset", 8'h05, 8'h00);
    chk("depth reset", 10'h080, 10'(O_JITTER_DEPTH_BITS));
    chk("corner reset", 10'h2a8, O_JITTER_CORNER_CHZ);
    wr(8'h02, 8'h04);
    wr(8'h04, 8'h15);
    wr(8'h01, 8'h00);
    rdchk("global kept", 8'h02, 8'h04);
    rdchk("jitter default", 8'h04, 8'h20);
    chk("standard kept", 10'h001, 10'(O_GLOBAL_LINE_STANDARD));
    wr(8'h02, 8'h00);
    run <= 1'b1;
    for (i = 0; i < 6; i++) begin
      t = tx_rows[i];
      wr(8'h05, t[55:48]);
      edge_sel <= t[50];
      inv <= t[51];
      pat_s <= t[47:32];
      pat_n <= t[31:16];
      marks(p, q, a);
      chk("pos marks", 10'(t[15:8]), 10'(p));
      chk("neg marks", 10'(t[7:0]), 10'(q));
      chk("line enable", 10'(!t[52]), 10'(O_TX_LINE_OE));
      chk("power down", 10'(t[52]), 10'(O_TX_POWER_DOWN));
      if (!t[49]) chk("alternation", 10'h000, 10'(a));
    end
    // All zeros after a soft reset must come out as substitution codes
    pat_s <= 16'h0000;
    repeat (16) @(posedge I_SYS_CLK);
    wr(8'h01, 8'h00);
    marks(p, q, a);
    chk("substitution pos", 10'h004, 10'(p));
    chk("substitution neg", 10'h004, 10'(q));
    // Same zeros in T1/J1 give the eight-bit code, still two pulses of each sign per eight bits
    wr(8'h02, 8'h04);
    wr(8'h01, 8'h00);
    marks(p, q, a);
    chk("b8zs pos", 10'h004, 10'(p));
    chk("b8zs neg", 10'h004, 10'(q));
    end_sim();
  end
endmodule
